// file: dv/dipcfg_assertions.sv
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module dipcfg_assertions (
  input wire mclk,
  input wire reset_n,
  input wire frame_busy,
  input wire [7:0] node_address,
  input wire node_broadcast,
  input wire [15:0] baud_divisor,
  input wire [1:0] rate_sel,
  input wire hreadyout,
  input wire hresp,
  input wire [3:0] char_data_bits,
  input wire parity_en,
  input wire [1:0] char_stop_bits
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_bcast_flag: assert property (node_broadcast == (node_address == 8'h00))
    else $error("broadcast flag wrong");
  a_rate_div: assert property (baud_divisor == (rate_sel == 2'h0 ? 16'h0411 :
    rate_sel == 2'h1 ? 16'h0208 : rate_sel == 2'h2 ? 16'h0104 : 16'h00ad))
    else $error("divisor wrong");
  a_char_fmt: assert property (char_data_bits == 4'h8 && !parity_en &&
    char_stop_bits == 2'h1) else $error("format wrong");
  a_frame_hold: assert property (frame_busy |=> $stable(node_address) &&
    $stable(rate_sel)) else $error("changed in frame");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus refused");
  sequence s_in_frame;
    frame_busy;
  endsequence
  a_div_hold: assert property (s_in_frame |=> $stable(baud_divisor))
    else $error("divisor changed in frame");
endmodule // dipcfg_assertions
bind dipcfg_decoder dipcfg_assertions dipcfg_assertions_i (.mclk(mclk), .reset_n(reset_n),
  .frame_busy(frame_busy), .node_address(node_address), .node_broadcast(node_broadcast),
  .baud_divisor(baud_divisor), .rate_sel(rate_sel), .hreadyout(hreadyout), .hresp(hresp),
  .char_data_bits(char_data_bits), .parity_en(parity_en), .char_stop_bits(char_stop_bits));

// file: dv/dipcfg_master_model.sv
// bus master model that marks serial frames in progress
`timescale 1ns/10ps
module dipcfg_master_model (
  input wire mclk,
  output logic frame_busy
);
  initial frame_busy = 1'b0;
  // 8n1 frame: start, 8 data, stop
  task frame(input int div);
    frame_busy <= 1'b1;
    repeat (10 * div) @(posedge mclk);
    frame_busy <= 1'b0;
  endtask
endmodule // dipcfg_master_model

// file: dv/tb.sv
// self-checking bench of the switch decoder
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0, reset_n = 1'b0, hw = 1'b0;
  logic [4:0] sw = 5'h15; // address 10 waiting at reset release
  logic [1:0] rs = 2'h3, ht = 2'h0;
  logic [31:0] ha = 32'h0, hd = 32'h0, rd;
  logic [15:0] dv [4] = '{16'h0411, 16'h0208, 16'h0104, 16'h00ad};
  wire [31:0] hr;
  wire rdy, fb, bc;
  wire [7:0] na;
  wire [15:0] bd;
  wire [1:0] rsel;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  dipcfg_master_model dipcfg_master_model_i (.mclk(mclk), .frame_busy(fb));
  dipcfg_decoder dipcfg_decoder_i (.mclk(mclk), .reset_n(reset_n),
    .addr_switch_weight1(sw[0]), .addr_switch_weight2(sw[1]), .addr_switch_weight4(sw[2]),
    .addr_switch_weight8(sw[3]), .addr_switch_weight16(sw[4]), .rate_select_low(rs[0]),
    .rate_select_high(rs[1]), .frame_busy(fb), .hsel(1'b1), .haddr(ha), .htrans(ht),
    .hwrite(hw), .hsize(3'h2), .hwdata(hd), .hready(rdy), .hrdata(hr), .hreadyout(rdy),
    .hresp(), .node_address(na), .node_broadcast(bc), .baud_divisor(bd), .rate_sel(rsel),
    .char_data_bits(), .parity_en(), .char_stop_bits());
  initial forever #50 mclk = ~mclk;
  // one ahb-lite single transfer
  task xfer(input [7:0] a, input w, input [31:0] d);
    @(posedge mclk);
    {ht, ha, hw} <= {2'h2, 24'h0, a, w};
    do @(posedge mclk); while (rdy !== 1'b1);
    {ht, hd} <= {2'h0, d};
    do @(posedge mclk); while (rdy !== 1'b1);
    rd = hr;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task latch;
    xfer(8'h00, 1'b1, 32'h2);
    repeat (4) @(posedge mclk);
  endtask
  task t_addr;
    for (int i = 0; i < 32; i++)
    begin
      sw <= ~i[4:0];
      latch();
      chk(na, i);
      chk(bc, i == 0);
    end
  endtask
  task t_rate;
    for (int r = 0; r < 4; r++)
    begin
      rs <= ~r[1:0];
      latch();
      chk(rsel, r);
      chk(bd, dv[r]);
    end
  endtask
  task t_ovr;
    xfer(8'h04, 1'b1, 32'h80);
    xfer(8'h00, 1'b1, 32'h1);
    repeat (4) @(posedge mclk);
    chk(na, 8'h80);
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd[8:0], 9'h080);
    xfer(8'h10, 1'b0, 32'h0);
    chk(rd, 32'h0);
    xfer(8'h0c, 1'b0, 32'h0);
    chk(rd, 32'h7f);
    xfer(8'h00, 1'b1, 32'h0);
    repeat (4) @(posedge mclk);
    chk(na, 8'h1f);
  endtask
  task t_hold;
    sw <= 5'h1f;
    latch();
    fork
      dipcfg_master_model_i.frame(16'h0411);
      begin
        sw <= 5'h1a;
        latch();
      end
    join_any
    chk(na, 8'h00);
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd[11], 1'b1);
    wait (fb === 1'b0);
    repeat (4) @(posedge mclk);
    chk(na, 8'h05);
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd[11:0], 12'h605);
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk)
    if (++cyc == 30000)
    begin
      n_fail++;
      test_done();
    end
  initial
  begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(na, 8'h0a);
    chk(bc, 1'b0);
    t_addr();
    t_rate();
    t_ovr();
    t_hold();
    test_done();
  end
endmodule // tb

// file: inc/dipcfg_defines.vh
// constants and register map of the dip switch node configuration decoder
// Notes on behaviour
// - address is binary-weighted sum of five switches, weight 1 to 16, off adds.
// - all switches on gives address zero, treated as the broadcast address.
// - master or software may assign another address, also above switch range.
// - rate switches pick 9600, 19200, 38400 or 57600 baud.
// - character format is 8 data bits, no parity, one stop bit.
`ifndef DIPCFG_DEFINES_VH
`define DIPCFG_DEFINES_VH
// register byte offsets
`define DIPCFG_CTRL_OFF 8'h00
`define DIPCFG_ADDR_OVR_OFF 8'h04
`define DIPCFG_STATUS_OFF 8'h08
`define DIPCFG_SWITCH_OFF 8'h0c
// control fields
`define DIPCFG_CTRL_OVR_EN 0
`define DIPCFG_CTRL_RELATCH 1
// status fields
`define DIPCFG_ST_ADDR_LSB 0
`define DIPCFG_ST_BCAST 8
`define DIPCFG_ST_RATE_LSB 9
`define DIPCFG_ST_PEND 11
// reset values
`define DIPCFG_CTRL_RST 1'h0
`define DIPCFG_ADDR_OVR_RST 8'h00
// rate selections
`define DIPCFG_RATE_9600 2'h0
`define DIPCFG_RATE_19200 2'h1
`define DIPCFG_RATE_38400 2'h2
`define DIPCFG_RATE_57600 2'h3
// clock and baud timing
`define DIPCFG_MCLK_HZ 10000000
`define DIPCFG_BAUD_9600 9600
`define DIPCFG_BAUD_19200 19200
`define DIPCFG_BAUD_38400 38400
`define DIPCFG_BAUD_57600 57600
// bit period in mclk cycles: mclk rate over baud, truncated, sized for the divisor port
`define DIPCFG_DIV_9600 16'h0411
`define DIPCFG_DIV_19200 16'h0208
`define DIPCFG_DIV_38400 16'h0104
`define DIPCFG_DIV_57600 16'h00ad
`define DIPCFG_DATA_BITS 4'h8
`define DIPCFG_STOP_BITS 2'h1
`endif

// file: rtl/dipcfg_decoder.v
// dip switch decoder for node address and serial bit rate, with ahb-lite registers
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "dipcfg_defines.vh"
module dipcfg_decoder (
  input wire mclk,
  input wire reset_n,
  input wire addr_switch_weight1,
  input wire addr_switch_weight2,
  input wire addr_switch_weight4,
  input wire addr_switch_weight8,
  input wire addr_switch_weight16,
  input wire rate_select_low,
  input wire rate_select_high,
  input wire frame_busy,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg [7:0] node_address,
  output reg node_broadcast,
  output reg [15:0] baud_divisor,
  output reg [1:0] rate_sel,
  output wire [3:0] char_data_bits,
  output wire parity_en,
  output wire [1:0] char_stop_bits
);

  // register file and switch latch state
  reg [0:0] ctrl_r;
  reg [7:0] addr_ovr_r;
  reg [4:0] sw_addr_r;
  reg [1:0] sw_rate_r;
  reg latched_r;
  reg pend_r;
  reg relatch_r;

  // bus data phase state
  reg wr_pend_r;
  reg [7:0] wr_off_r;
  reg [7:0] rd_off;
  reg [31:0] rd_nxt;

  // decode helpers
  reg [7:0] eff_addr;
  reg [15:0] div_nxt;
  wire [6:0] sw_raw;
  wire [6:0] sw_off;
  wire [4:0] sw_sum;
  wire [1:0] sw_rate;
  wire acc_ok;
  wire wr_ctrl;
  wire wr_ovr;
  wire latch_go;
  genvar gi;

  // switch levels, rate pair above the five address weights
  assign sw_raw = {rate_select_high, rate_select_low, addr_switch_weight16,
    addr_switch_weight8, addr_switch_weight4, addr_switch_weight2, addr_switch_weight1};

  // off position contributes its weight, so each switch is inverted
  // weighted address sum
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_sw_off
      assign sw_off[gi] = ~sw_raw[gi];
    end
  endgenerate
  assign sw_sum = sw_off[4:0];
  assign sw_rate = sw_off[6:5]; // first rate switch is the low code bit

  assign char_data_bits = `DIPCFG_DATA_BITS;
  assign parity_en = 1'b0;
  assign char_stop_bits = `DIPCFG_STOP_BITS;

  // slave always ready and answers okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc_ok = hsel & htrans[1] & hready;

  // write strobes, one per writable register
  assign wr_ctrl = wr_pend_r && (wr_off_r == `DIPCFG_CTRL_OFF);
  assign wr_ovr = wr_pend_r && (wr_off_r == `DIPCFG_ADDR_OVR_OFF);

  // latch after reset release or on request, never inside a frame
  assign latch_go = (!latched_r || pend_r || relatch_r) && !frame_busy;

  // address phase capture for writes
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend_r <= 1'b0;
      wr_off_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= acc_ok & hwrite;
      wr_off_r <= haddr[7:0];
    end
  end

  // control and override registers, written in the data phase
  // software address override
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r <= `DIPCFG_CTRL_RST;
      addr_ovr_r <= `DIPCFG_ADDR_OVR_RST;
      relatch_r <= 1'b0;
    end
    else
    begin
      relatch_r <= 1'b0;
      if (wr_ctrl)
      begin
        ctrl_r[`DIPCFG_CTRL_OVR_EN] <= hwdata[`DIPCFG_CTRL_OVR_EN];
        relatch_r <= hwdata[`DIPCFG_CTRL_RELATCH];
      end
      else if (wr_ovr)
        addr_ovr_r <= hwdata[7:0];
    end
  end

  // switch latch: once after reset release, again on request, never mid-frame
  // latch outside frames
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latched_r <= 1'b0;
      pend_r <= 1'b0;
      sw_addr_r <= 5'h00;
      sw_rate_r <= 2'h0;
    end
    else
    begin
      if (latch_go)
      begin
        latched_r <= 1'b1;
        pend_r <= 1'b0;
        sw_addr_r <= sw_sum;
        sw_rate_r <= sw_rate;
      end
      else if (relatch_r)
        pend_r <= 1'b1;
    end
  end

  // effective address: override when enabled, else latched switches
  // override selects address
  always @*
  begin
    eff_addr = {3'h0, sw_addr_r};
    if (ctrl_r[`DIPCFG_CTRL_OVR_EN])
      eff_addr = addr_ovr_r;
  end

  // divisor for the latched rate code
  // rate from two switches
  always @*
  begin
    div_nxt = `DIPCFG_DIV_9600;
    case (sw_rate_r)
      `DIPCFG_RATE_19200: div_nxt = `DIPCFG_DIV_19200;
      `DIPCFG_RATE_38400: div_nxt = `DIPCFG_DIV_38400;
      `DIPCFG_RATE_57600: div_nxt = `DIPCFG_DIV_57600;
      default: div_nxt = `DIPCFG_DIV_9600;
    endcase
  end

  // active settings only move between frames
  // zero is broadcast
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      node_address <= 8'h00;
      node_broadcast <= 1'b1;
      baud_divisor <= `DIPCFG_DIV_9600;
      rate_sel <= `DIPCFG_RATE_9600;
    end
    else if (!frame_busy)
    begin
      node_address <= eff_addr;
      node_broadcast <= (eff_addr == 8'h00);
      baud_divisor <= div_nxt;
      rate_sel <= sw_rate_r;
    end
  end

  // read mux on the address phase offset; unmapped offsets read zero
  always @*
  begin
    rd_off = haddr[7:0];
    rd_nxt = 32'h00000000;
    if (rd_off == `DIPCFG_CTRL_OFF)
      rd_nxt = {31'h00000000, ctrl_r[`DIPCFG_CTRL_OVR_EN]};
    else if (rd_off == `DIPCFG_ADDR_OVR_OFF)
      rd_nxt = {24'h000000, addr_ovr_r};
    else if (rd_off == `DIPCFG_STATUS_OFF)
      rd_nxt = {20'h00000, pend_r, rate_sel, node_broadcast, node_address};
    else if (rd_off == `DIPCFG_SWITCH_OFF)
      rd_nxt = {25'h0000000, sw_rate_r, sw_addr_r};
  end

  // read data, registered at the end of the address phase
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata <= 32'h00000000;
    else if (acc_ok && !hwrite)
      hrdata <= rd_nxt;
  end

endmodule // dipcfg_decoder
